// *** verilog/bsl_map.svh ***
// Register indices, field positions, reset values and timing counts of the speed loop.
// Assumes a 32-bit AXI4-Lite bus; byte address of a register is four times its index.
`ifndef BSL_MAP_SVH
`define BSL_MAP_SVH

`define BSL_IDX_CTRL 4'h0
`define BSL_IDX_MODULUS 4'h1
`define BSL_IDX_OPEN_GAIN 4'h2
`define BSL_IDX_LOOP_GAIN 4'h3
`define BSL_IDX_GAIN_SETPT 4'h4
`define BSL_IDX_LEAD 4'h5
`define BSL_IDX_LEAD_SETPT 4'h6
`define BSL_IDX_ERR_GAIN 4'h7
`define BSL_IDX_POLE_ONE 4'h8
`define BSL_IDX_ZERO_ONE 4'h9
`define BSL_IDX_POLE_TWO 4'ha
`define BSL_IDX_ZERO_TWO 4'hb
`define BSL_IDX_STATUS 4'hc
`define BSL_IDX_REF_FREQ 4'hd
`define BSL_IDX_FB_FREQ 4'he
`define BSL_IDX_APPLIED_GAIN 4'hf
`define BSL_NUM_WR 12

`define BSL_CTRL_AUTO_GAIN 0
`define BSL_CTRL_AUTO_LEAD 1
`define BSL_CTRL_FBSEL_LSB 2

`define BSL_CFG_RST 16'h0000
`define BSL_MODULUS_VALUE 12'hf82

`define BSL_CLK_HZ 20000000
`define BSL_GATE_MS 1000
`define BSL_GATE_CYCLES (`BSL_CLK_HZ / 1000 * `BSL_GATE_MS)
`define BSL_LEAD_DIV 1000
`define BSL_STEPS 6

`endif

// *** verilog/bsl_pkg.sv ***
// Types shared by the speed loop modules.
// Assumes nothing of its surroundings.
package bsl_pkg;
  typedef enum logic [2:0] {
    BSL_ST_IDLE = 3'b001,
    BSL_ST_SPINUP = 3'b010,
    BSL_ST_CLOSED = 3'b100
  } bsl_state_e;
  typedef logic [11:0] bsl_field_t;
endpackage

// *** verilog/bsl_meas_if.sv ***
// Result of one frequency and period measurement.
// Assumes a single clock shared by meter and consumer.
`timescale 1ns/100ps
interface bsl_meas_if;
  logic [15:0] freq;
  logic [23:0] period;
  logic update;
  modport src (output freq, output period, output update);
  modport snk (input freq, input period, input update);
endinterface

// *** verilog/bsl_freq_meter.sv ***
// Edge counter over a fixed gate window and period timer between rising edges.
// Assumes the measured input is already synchronous to aclk.
`timescale 1ns/100ps
`include "bsl_map.svh"
module bsl_freq_meter #(
  parameter int GATE_CYCLES = `BSL_GATE_CYCLES
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sig,
  bsl_meas_if.src m
);
  logic sig_q, next_sig_q, rise;
  logic [31:0] win, next_win;
  logic [15:0] edges, next_edges, next_freq;
  logic [23:0] per_cnt, next_per_cnt, next_period;
  logic next_update;

  always_comb begin
    rise = sig && !sig_q;
    next_sig_q = sig;
    next_edges = rise ? edges + 16'h1 : edges;
    next_per_cnt = (per_cnt == 24'hffffff) ? per_cnt : per_cnt + 24'h1;
    next_period = m.period;
    next_freq = m.freq;
    next_update = 1'b0;
    next_win = win + 32'h1;
    if (rise) begin
      next_period = per_cnt + 24'h1;
      next_per_cnt = 24'h0;
    end
    // Window end publishes the count, so the result is in edges per gate
    if (win >= 32'(GATE_CYCLES - 1)) begin
      next_win = 32'h0;
      next_freq = next_edges;
      next_edges = 16'h0;
      next_update = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sig_q <= 1'b0;
      win <= 32'h0;
      edges <= 16'h0;
      per_cnt <= 24'h0;
      m.freq <= 16'h0;
      m.period <= 24'h0;
      m.update <= 1'b0;
    end else begin
      sig_q <= next_sig_q;
      win <= next_win;
      edges <= next_edges;
      per_cnt <= next_per_cnt;
      m.freq <= next_freq;
      m.period <= next_period;
      m.update <= next_update;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_update_pulse;
    m.update |=> !m.update;
  endproperty
  a_update_pulse: assert property (p_update_pulse) else $error("meter update longer than one cycle");
endmodule // bsl_freq_meter

// *** verilog/bsl_speed_loop.sv ***
// Speed-control loop of a sensored brushless motor driver in clock frequency mode, with AXI4-Lite registers.
// Assumes hall, reference clock, feedback sense and enable inputs synchronous to aclk.
// Summary of operation
// - Until lock goes low, drive open-loop using the open-loop gain register.
// - With auto gain, scaled gain is loop gain times reference frequency over setpoint.
// - With auto lead, scaled lead is lead times hall frequency over lead setpoint.
// - Each lead unit moves commutation one thousandth of the hall period earlier.
// - The lead setpoint is ignored unless auto lead is enabled.
// - Feedback select zero takes speed feedback from the first hall input.
// - With auto lead off, a lead write acts at once while running.
// - Four coefficients set pole one, zero one, pole two and zero two.
// - Total gain is loop gain, or scaled gain with auto gain, times 2*z1/p1 times 0.5*z2/p2.
// - Locked only when feedback frequency equals reference frequency.
// - New total gain applies at restart, or at lock fall with auto gain.
// - Enable low stops the motor; enable high again restarts spin-up.
`timescale 1ns/100ps
`include "bsl_map.svh"
module bsl_speed_loop
#(
  parameter int GATE_CYCLES = `BSL_GATE_CYCLES
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic enable,
  input wire logic ref_clk_in,
  input wire logic [2:0] hall,
  input wire logic fb_sense,
  output logic lock_indicator_n,
  output logic speed_feedback_out,
  output logic [2:0] comm_code,
  output logic [11:0] drive_level
);
  import bsl_pkg::*;
  logic auto_gain, auto_lead, fb_sel;
  bsl_meas_if mr();
  bsl_meas_if mf();
  bsl_meas_if mh();
  bsl_freq_meter #(.GATE_CYCLES(GATE_CYCLES)) u_ref (.aclk(aclk), .aresetn(aresetn), .sig(ref_clk_in), .m(mr));
  bsl_freq_meter #(.GATE_CYCLES(GATE_CYCLES)) u_fb (.aclk(aclk), .aresetn(aresetn), .sig(fb_sel), .m(mf));
  bsl_freq_meter #(.GATE_CYCLES(GATE_CYCLES)) u_hall (.aclk(aclk), .aresetn(aresetn), .sig(hall[0]), .m(mh));
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[7:6] == 2'b00) && (a[1:0] == 2'b00);
  endfunction
  function automatic logic [2:0] next_step(input logic [2:0] h);
    case (h)
      3'b001: return 3'b011;
      3'b011: return 3'b010;
      3'b010: return 3'b110;
      3'b110: return 3'b100;
      3'b100: return 3'b101;
      3'b101: return 3'b001;
      default: return h;
    endcase
  endfunction
  // Register bus
  logic [15:0] cfg [`BSL_NUM_WR], next_cfg [`BSL_NUM_WR];
  logic aw_hold, next_aw_hold, w_hold, next_w_hold, next_bvalid, next_rvalid, next_awready, next_wready;
  logic next_arready;
  logic [7:0] aw_q, next_aw_q, next_ar_q;
  logic [31:0] wd_q, next_wd_q, next_rdata;
  logic [3:0] ws_q, next_ws_q;
  logic [1:0] next_bresp, next_rresp;
  logic [15:0] applied_gain, next_applied, total_gain;
  bsl_state_e state, next_state;
  function automatic logic [15:0] rd_word(input logic [3:0] idx);
    case (idx)
      `BSL_IDX_STATUS: return {11'h0, cfg[`BSL_IDX_MODULUS][11:0] == `BSL_MODULUS_VALUE, state, !lock_indicator_n};
      `BSL_IDX_REF_FREQ: return mr.freq;
      `BSL_IDX_FB_FREQ: return mf.freq;
      `BSL_IDX_APPLIED_GAIN: return applied_gain;
      default: return cfg[idx];
    endcase
  endfunction
  always_comb begin
    next_cfg = cfg;
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_q = aw_q;
    next_wd_q = wd_q;
    next_ws_q = ws_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_ar_q = araddr;
    if (awvalid && awready) begin
      next_aw_hold = 1'b1;
      next_aw_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_hold = 1'b1;
      next_wd_q = wdata;
      next_ws_q = wstrb;
    end
    if (bvalid && bready) next_bvalid = 1'b0;
    // Address and data may arrive in either order; commit once both are held
    if (aw_hold && w_hold && !bvalid) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = 2'b10;
      if (is_mapped(aw_q) && aw_q[5:2] < 4'(`BSL_NUM_WR)) begin
        next_bresp = 2'b00;
        for (int b = 0; b < 2; b++) begin
          if (ws_q[b]) next_cfg[aw_q[5:2]][8*b +: 8] = wd_q[8*b +: 8];
        end
      end
    end
    if (rvalid && rready) next_rvalid = 1'b0;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = is_mapped(next_ar_q) ? 2'b00 : 2'b10;
      next_rdata = is_mapped(next_ar_q) ? {16'h0, rd_word(next_ar_q[5:2])} : 32'h0;
    end
    next_awready = !next_aw_hold;
    next_wready = !next_w_hold;
    next_arready = !next_rvalid;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `BSL_NUM_WR; i++) cfg[i] <= `BSL_CFG_RST;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
    end else begin
      cfg <= next_cfg;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_q <= next_aw_q;
      wd_q <= next_wd_q;
      ws_q <= next_ws_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
    end
  end
  // Loop arithmetic; wide dividers trade area for a single-cycle answer
  bsl_field_t loop_g, gsp, lead, lsp, eg, p1, z1, p2, z2, next_drive;
  logic [27:0] scaled_gain, lead_eff;
  logic [51:0] num_tg, quo_tg, shift_w;
  logic [23:0] den_tg, shift, step, tmr_load, tmr, next_tmr;
  always_comb begin
    loop_g = cfg[`BSL_IDX_LOOP_GAIN][11:0];
    gsp = cfg[`BSL_IDX_GAIN_SETPT][11:0];
    lead = cfg[`BSL_IDX_LEAD][11:0];
    lsp = cfg[`BSL_IDX_LEAD_SETPT][11:0];
    eg = cfg[`BSL_IDX_ERR_GAIN][11:0];
    p1 = cfg[`BSL_IDX_POLE_ONE][11:0];
    z1 = cfg[`BSL_IDX_ZERO_ONE][11:0];
    p2 = cfg[`BSL_IDX_POLE_TWO][11:0];
    z2 = cfg[`BSL_IDX_ZERO_TWO][11:0];
    auto_gain = cfg[`BSL_IDX_CTRL][`BSL_CTRL_AUTO_GAIN];
    auto_lead = cfg[`BSL_IDX_CTRL][`BSL_CTRL_AUTO_LEAD];
    fb_sel = (cfg[`BSL_IDX_CTRL][`BSL_CTRL_FBSEL_LSB +: 2] == 2'b00) ? hall[0] : fb_sense;
    scaled_gain = (auto_gain && gsp != 12'h0) ? 28'(loop_g) * 28'(mr.freq) / 28'(gsp) : 28'(loop_g);
    // 2*z1/p1 * 0.5*z2/p2 reduces to z1*z2/(p1*p2)
    num_tg = 52'(scaled_gain) * 52'(z1) * 52'(z2);
    den_tg = 24'(p1) * 24'(p2);
    quo_tg = (den_tg == 24'h0) ? 52'h0 : num_tg / 52'(den_tg);
    total_gain = (quo_tg > 52'hffff) ? 16'hffff : quo_tg[15:0];
    lead_eff = (auto_lead && lsp != 12'h0) ? 28'(lead) * 28'(mh.freq) / 28'(lsp) : 28'(lead);
    shift_w = 52'(mh.period) * 52'(lead_eff) / 52'(`BSL_LEAD_DIV);
    shift = (shift_w > 52'hffffff) ? 24'hffffff : shift_w[23:0];
    step = mh.period / 24'(`BSL_STEPS);
    tmr_load = (step > shift) ? step - shift : 24'h0;
  end
  // Run control, lock, gain latch and drive
  logic next_lock_n, match, latch_now, next_fb_out, tmr_on, next_tmr_on;
  logic signed [16:0] err;
  logic signed [47:0] corr, dsum;
  always_comb begin
    next_state = state;
    next_lock_n = lock_indicator_n;
    next_drive = drive_level;
    next_fb_out = fb_sel;
    match = (mr.freq == mf.freq) && (mr.freq != 16'h0);
    err = $signed({1'b0, mr.freq}) - $signed({1'b0, mf.freq});
    corr = 48'(err) * 48'($signed({1'b0, eg})) * 48'($signed({1'b0, applied_gain}));
    dsum = 48'($signed({1'b0, drive_level})) + (corr >>> 16);
    case (state)
      BSL_ST_IDLE: begin
        next_lock_n = 1'b1;
        next_drive = 12'h0;
        if (enable) next_state = BSL_ST_SPINUP;
      end
      BSL_ST_SPINUP: begin
        next_drive = cfg[`BSL_IDX_OPEN_GAIN][11:0];
        if (mf.update && match) begin
          next_state = BSL_ST_CLOSED;
          next_lock_n = 1'b0;
        end
      end
      BSL_ST_CLOSED: begin
        if (mf.update) begin
          next_lock_n = !match;
          next_drive = (dsum < 0) ? 12'h0 : (dsum > 48'sd4095) ? 12'hfff : dsum[11:0];
        end
      end
      default: next_state = BSL_ST_IDLE;
    endcase
    if (!enable) begin
      next_state = BSL_ST_IDLE;
      next_lock_n = 1'b1;
      next_drive = 12'h0;
    end
    // Coefficient edits while spinning wait for a restart or an auto-gain lock fall
    latch_now = (state == BSL_ST_IDLE && enable) || (auto_gain && lock_indicator_n && !next_lock_n);
    next_applied = latch_now ? total_gain : applied_gain;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= BSL_ST_IDLE;
      lock_indicator_n <= 1'b1;
      drive_level <= 12'h0;
      applied_gain <= 16'h0;
      speed_feedback_out <= 1'b0;
    end else begin
      state <= next_state;
      lock_indicator_n <= next_lock_n;
      drive_level <= next_drive;
      applied_gain <= next_applied;
      speed_feedback_out <= next_fb_out;
    end
  end
  // Commutation with lead; lead is read live so edits act at once
  logic [2:0] hall_q, next_hall_q, next_comm;
  always_comb begin
    next_hall_q = hall;
    next_comm = comm_code;
    next_tmr = tmr;
    next_tmr_on = tmr_on;
    if (state == BSL_ST_IDLE) begin
      next_comm = 3'h0;
      next_tmr_on = 1'b0;
    end else if (hall != hall_q || comm_code == 3'h0) begin
      next_comm = (lead_eff != 28'h0 && tmr_load == 24'h0) ? next_step(hall) : hall;
      next_tmr = tmr_load;
      next_tmr_on = (lead_eff != 28'h0) && (tmr_load != 24'h0);
    end else if (tmr_on) begin
      next_tmr = tmr - 24'h1;
      if (tmr <= 24'h1) begin
        next_comm = next_step(hall_q);
        next_tmr_on = 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hall_q <= 3'h0;
      comm_code <= 3'h0;
      tmr <= 24'h0;
      tmr_on <= 1'b0;
    end else begin
      hall_q <= next_hall_q;
      comm_code <= next_comm;
      tmr <= next_tmr;
      tmr_on <= next_tmr_on;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_spinup_open;
    state == BSL_ST_SPINUP && enable |=> drive_level == $past(cfg[`BSL_IDX_OPEN_GAIN][11:0]);
  endproperty
  a_spinup_open: assert property (p_spinup_open) else $error("spin-up drive not open-loop gain");
  property p_auto_gain;
    auto_gain && gsp != 12'h0 |-> 40'(scaled_gain) * 40'(gsp) <= 40'(loop_g) * 40'(mr.freq)
      && 40'(loop_g) * 40'(mr.freq) < 40'(scaled_gain + 28'h1) * 40'(gsp);
  endproperty
  a_auto_gain: assert property (p_auto_gain) else $error("auto gain scaling wrong");
  property p_lead_fixed;
    !auto_lead |-> lead_eff == 28'(lead);
  endproperty
  a_lead_fixed: assert property (p_lead_fixed) else $error("lead setpoint used with auto lead off");
  property p_fb_select;
    cfg[`BSL_IDX_CTRL][`BSL_CTRL_FBSEL_LSB +: 2] == 2'b00 |=> speed_feedback_out == $past(hall[0]);
  endproperty
  a_fb_select: assert property (p_fb_select) else $error("feedback not from first hall input");
  property p_lock_match;
    $fell(lock_indicator_n) |-> $past(mr.freq) == $past(mf.freq) && $past(mf.update);
  endproperty
  a_lock_match: assert property (p_lock_match) else $error("lock without frequency match");
  property p_gain_hold;
    !latch_now |=> $stable(applied_gain);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("total gain changed outside restart or lock");
  property p_gain_restart;
    state == BSL_ST_IDLE && enable |=> applied_gain == $past(total_gain) && state == BSL_ST_SPINUP;
  endproperty
  a_gain_restart: assert property (p_gain_restart) else $error("restart did not latch gain");
  property p_enable_stop;
    !enable |=> state == BSL_ST_IDLE && drive_level == 12'h0 && lock_indicator_n ##1 comm_code == 3'h0;
  endproperty
  a_enable_stop: assert property (p_enable_stop) else $error("enable low did not stop motor");
  property p_bvalid_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
  c_lock: cover property ($fell(lock_indicator_n));
  c_lead_step: cover property (tmr_on && tmr == 24'h1);
  c_write: cover property (bvalid && bready && bresp == 2'b00);
  c_auto_latch: cover property (auto_gain && latch_now && state == BSL_ST_SPINUP);
endmodule // bsl_speed_loop

// *** test/bsl_motor_model.sv ***
// Behavioural stand-in for the rotor, its three Hall sensors and a separate feedback sense trace.
// Assumes the block's drive level powers the rotor; with zero drive the rotor stops and the sensors hold.
`timescale 1ns/100ps
module bsl_motor_model #(
  parameter int STEP_CYCLES = 5
)(
  input wire logic aclk,
  input wire logic [11:0] drive_level,
  output logic [2:0] hall,
  output logic fb_sense
);
  logic [2:0] seq [6] = '{3'b001, 3'b011, 3'b010, 3'b110, 3'b100, 3'b101};
  int step = 0;
  int cnt = 0;
  initial begin
    hall = 3'b001;
    fb_sense = 1'b0;
  end
  // Speed is fixed while driven, so lock depends only on the reference period chosen by the bench
  always @(posedge aclk) begin
    if (drive_level != 12'h000) begin
      if (cnt == STEP_CYCLES - 1) begin
        cnt <= 0;
        step <= (step + 1) % 6;
        hall <= seq[(step + 1) % 6];
        // Sense trace toggles once a turn, so it runs at half the first Hall frequency
        if (step == 5) fb_sense <= ~fb_sense;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // bsl_motor_model

// *** test/bsl_speed_loop_bench.sv ***
// Self-checking bench for the speed loop: register bus, spin-up, lock, lead and gain timing.
// Assumes the motor stand-in of bsl_motor_model and a gate window shortened to 240 cycles.
`timescale 1ns/100ps
module bsl_speed_loop_bench;
  import bsl_pkg::*;
  localparam int GATE = 240;
  localparam int STEP = 5;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic enable = 0, ref_clk_in = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, lock_indicator_n, speed_feedback_out, fb_sense;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [2:0] hall, comm_code;
  logic [11:0] drive_level;
  int bad_count = 0, check_count = 0, rc = 0;
  logic [2:0] nxt [8] = '{3'b000, 3'b011, 3'b110, 3'b010, 3'b101, 3'b001, 3'b100, 3'b000};

  bsl_speed_loop #(.GATE_CYCLES(GATE)) dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .enable(enable),
    .ref_clk_in(ref_clk_in), .hall(hall), .fb_sense(fb_sense), .lock_indicator_n(lock_indicator_n),
    .speed_feedback_out(speed_feedback_out), .comm_code(comm_code), .drive_level(drive_level));
  bsl_motor_model #(.STEP_CYCLES(STEP)) motor (.aclk(aclk), .drive_level(drive_level), .hall(hall),
    .fb_sense(fb_sense));

  initial begin
    forever #25 aclk = ~aclk;
  end
  // Reference period is one rotor turn; a gate of eight whole periods counts eight edges at any phase
  always @(posedge aclk) begin
    rc <= (rc == 6 * STEP - 1) ? 0 : rc + 1;
    ref_clk_in <= (rc < 3 * STEP);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 0;
    r = 2'b11;
    @(posedge aclk);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        r = bresp;
        bready <= 0;
        done = 1;
      end
    end
    chk(done, 1);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 0;
    d = 32'h0;
    r = 2'b11;
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 0;
        done = 1;
      end
    end
    chk(done, 1);
  endtask

  task automatic wr(input int i, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(8'(i * 4), d, r);
    chk(r, 2'b00);
  endtask

  task automatic rd(input int i, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(8'(i * 4), d, r);
    chk(r, 2'b00);
  endtask

  task automatic wait_lock(input logic lvl, input int lim);
    int n;
    n = 0;
    while (lock_indicator_n !== lvl && n < lim) begin
      @(posedge aclk);
      n++;
    end
    chk(lock_indicator_n, lvl);
  endtask

  // Counts cycles in which commutation already shows the step after the present Hall code
  task automatic lead_count(output int c);
    c = 0;
    repeat (60) begin
      @(posedge aclk);
      if (comm_code === nxt[hall]) c++;
    end
  endtask

  task automatic t_regs();
    logic [1:0] r;
    chk({lock_indicator_n, comm_code, drive_level}, 32'h8000);
    axi_wr(8'h30, 32'h1, r);
    chk(r, 2'b10);
    axi_rd(8'h40, v, r);
    chk(r, 2'b10);
    chk(v, 32'h0);
    rd(12, v);
    chk(v, 32'h2);
    for (int i = 0; i < 12; i++) begin
      rd(i, v);
      chk(v, 32'h0);
    end
    for (int i = 1; i < 12; i++) begin
      wr(i, 32'h0a50 + i);
      rd(i, v);
      chk(v, 32'h0a50 + i);
    end
    $display("test regs done");
  endtask

  task automatic t_spin();
    wr(1, 32'd3970);
    wr(2, 32'hfa0);
    wr(3, 32'd100);
    wr(5, 32'h0);
    wr(6, 32'h3e8);
    wr(8, 32'd4);
    wr(9, 32'd2);
    wr(10, 32'd2);
    wr(11, 32'd6);
    wr(0, 32'h0);
    rd(12, v);
    chk(v, 32'h12);
    enable <= 1;
    // Spin-up is entered one edge after enable and the drive register follows one edge later
    repeat (3) @(posedge aclk);
    chk(drive_level, 32'hfa0);
    chk(lock_indicator_n, 1);
    rd(12, v);
    chk(v, 32'h14);
    rd(15, v);
    chk(v, 32'd150);
    $display("test spin done");
  endtask

  task automatic t_lock();
    int c;
    logic p;
    wait_lock(0, 1500);
    rd(13, v);
    chk(v, 32'd8);
    rd(14, v);
    chk(v, 32'd8);
    rd(12, v);
    chk(v, 32'h19);
    c = 0;
    repeat (40) begin
      p = hall[0];
      @(posedge aclk);
      if (speed_feedback_out !== p) c++;
    end
    chk(c, 0);
    $display("test lock done");
  endtask

  task automatic t_lead();
    int c;
    lead_count(c);
    chk(c, 0);
    wr(5, 32'd100);
    lead_count(c);
    chk(c > 0, 1);
    // Auto lead with setpoint 1000 at 8 turns per gate scales 100 down to 0
    wr(0, 32'h2);
    lead_count(c);
    chk(c, 0);
    // Setpoint 4 scales the lead to 200, past one step, so commutation leads at once
    wr(6, 32'd4);
    lead_count(c);
    chk(c > 0, 1);
    wr(0, 32'h0);
    wr(5, 32'h0);
    $display("test lead done");
  endtask

  task automatic t_gain();
    wr(9, 32'd4);
    rd(15, v);
    chk(v, 32'd150);
    enable <= 0;
    repeat (3) @(posedge aclk);
    chk({lock_indicator_n, comm_code, drive_level}, 32'h8000);
    rd(12, v);
    chk(v, 32'h12);
    wr(0, 32'h1);
    wr(4, 32'd4);
    enable <= 1;
    repeat (2) @(posedge aclk);
    rd(15, v);
    chk(v, 32'd600);
    wait_lock(0, 1500);
    wr(9, 32'd2);
    rd(15, v);
    chk(v, 32'd600);
    wr(0, 32'h5);
    wait_lock(1, 1000);
    wr(0, 32'h1);
    wait_lock(0, 1500);
    rd(15, v);
    chk(v, 32'd300);
    enable <= 0;
    $display("test gain done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run is near 1700 cycles; the limit leaves ample margin
  initial begin
    #(50 * 30000);
    bad_count++;
    $display("watchdog expired at %0t", $time);
    end_sim();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_spin();
    t_lock();
    t_lead();
    t_gain();
    end_sim();
  end
endmodule // bsl_speed_loop_bench
